// ==== rtl/dai_top.sv ====
// diagnostic alarm detection, status latching, interrupt pins and modem queues
// Behaviour
// [R1] alarm only once consecutive failures exceed fault limit by one
// [R2] high and low violations both advance the same failure counter
// [R3] active alarm releases only inside limits shrunk by hysteresis; code also releases it when the channel is disabled
// [R4] aux and temperature channels alarm below low or above high limit
// [R5] low all zeros with high all ones disables; disabled after reset
// [R6] limit fields hold upper eight bits; high fills ones, low zeros
// [R7] fixed windows for reference-half and supply-sixth diagnostics
// [R8] fixed windows for core-supply and bias diagnostics
// [R9] output diagnostic window is expected code plus and minus margin
// [R10] expected code is the twelve top bits of the dac code
// [R11] each status register has a mask; 1 blocks; masks reset to 1
// [R12] sticky bit set by condition; read clears only if condition gone
// [R13] mode bit 1 level (reset), 0 edge with one 813 ns pulse
// [R14] level interrupt holds until condition gone and status read
// [R15] polarity bit 1 active high, 0 active low
// [R16] edge events synchronised to 307.2 kHz tick before pulse
// [R17] per register interrupt is OR of bits; edges from per bit events
// [R18] unmask with sticky set: level fires now, edge waits new event
// [R19] alarm register drives alarm pin; others drive enabled irq pin
// [R20] queue flags are not sticky and follow present queue state
// [R21] queues hold 32 entries of 9 bits; parity passed unchanged
// [R22] received character with bad stop bit dropped, frame error set
// [R23] serial input character with bad stop bit dropped, error set
// [R24] host waits for interrupt message end before new serial input
// [R25] return within limits before count reached restarts the count
// [R26] hysteresis field spans 0 to 127 codes
// [R27] independent counter and alarm state per channel per conversion
`timescale 1ns/1ps

module dai_queue
    import dai_pkg::*;
(
    input  wire logic          clk,      // block clock
    input  wire logic          rst_n,    // synchronous reset
    input  wire logic          push,     // enqueue request
    input  wire logic [QW-1:0] push_data,// character with parity
    input  wire logic          pop,      // dequeue request
    output logic [QW-1:0]      head,     // oldest character
    output logic               empty,    // queue empty
    output logic               full      // queue full
);
    logic [QW-1:0]  mem [QDEPTH];
    logic [QPW-1:0] wr_ptr_reg;
    logic [QPW-1:0] rd_ptr_reg;
    logic [QPW:0]   count_reg;

    assign empty = (count_reg == '0);
    assign full  = (count_reg == (QPW+1)'(QDEPTH));
    assign head  = mem[rd_ptr_reg];

    always_ff @(posedge clk) begin
        if (push && !full) begin
            mem[wr_ptr_reg] <= push_data; // R21
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop && !empty) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (QPW+1)'(push && !full) - (QPW+1)'(pop && !empty);
        end
    end
endmodule

module dai_top
    import dai_pkg::*;
(
    input  wire logic                   MCLK,     // 40 MHz block clock
    input  wire logic                   RST_N,    // synchronous reset, low
    input  wire logic [dai_pkg::AW-1:0] ADDR,     // register byte address
    input  wire logic [dai_pkg::DW-1:0] WDATA,    // register write data
    input  wire logic                   WR,       // write strobe
    input  wire logic                   RD,       // read strobe
    output logic [dai_pkg::DW-1:0]      RDATA,    // read data, next cycle
    input  wire dai_pkg::dai_conv_s     CONV,     // completed conversion
    input  wire logic [15:0]            DAC_CODE, // present dac input code
    input  wire dai_pkg::dai_char_s     DEMOD_CH, // demodulated character
    input  wire dai_pkg::dai_char_s     SER_CH,   // serial input character
    input  wire logic                   TXQ_POP,  // modulator takes head
    output logic [dai_pkg::QW-1:0]      TXQ_DATA, // transmit queue head
    output logic                        TXQ_VALID,// transmit queue not empty
    input  wire logic                   RXQ_POP,  // serial output takes head
    output logic [dai_pkg::QW-1:0]      RXQ_DATA, // receive queue head
    output logic                        RXQ_VALID,// receive queue not empty
    output logic                        IRQ,      // interrupt pin
    output logic                        ALARM     // alarm pin
);
    import dai_pkg::*;

    logic [2:0]         config_reg;
    logic [FLT_W-1:0]   flt_limit_reg;
    logic [ALARM_HYSTERESIS_W-1:0]  alarm_hysteresis_reg;
    logic [7:0]         lim_lo_reg [3];
    logic [7:0]         lim_hi_reg [3];
    logic [GEN_W-1:0]   gen_st_reg, gen_msk_reg;
    logic [MDM_W-1:0]   mdm_st_reg, mdm_msk_reg, mdm_cond_d_reg;
    logic [NCH-1:0]     alm_st_reg, alm_msk_reg, alm_cond_d_reg;
    logic [NCH-1:0]     alarm_reg;
    logic [FLT_W-1:0]   fail_cnt_reg [NCH];
    logic [DW-1:0]      rdata_reg;
    logic [7:0]         tick_cnt_reg;
    logic               tick;
    logic               tx_empty, tx_full, rx_empty, rx_full;
    logic [GEN_W-1:0]   gen_cond;
    logic [MDM_W-1:0]   mdm_cond;
    logic               rd_gen, rd_mdm, rd_alm;
    logic               irq_evt, alm_evt, interrupt_mode_select, alm_lvl, irq_pulse, alm_pulse;
    dai_limit_s         lim;
    logic [RW:0]        res_x, alarm_hysteresis_x;
    logic               out_of_lim, inside_alarm_hysteresis, ch_disabled;

    function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // aux/temp limit expansion from the 8-bit fields
    function automatic dai_limit_s aux_lim(input logic [7:0] lo8, input logic [7:0] hi8);
        aux_lim.lo = {lo8, LO_FILL}; // R6
        aux_lim.hi = {hi8, HI_FILL}; // R6
    endfunction

    // limits for the converted channel
    always_comb begin
        logic [RW-1:0] exp_code;
        exp_code = DAC_CODE[15:4]; // R10
        lim      = aux_lim(lim_lo_reg[0], lim_hi_reg[0]);
        case (CONV.ch)
            CH_AUX0: lim = aux_lim(lim_lo_reg[0], lim_hi_reg[0]);
            CH_AUX1: lim = aux_lim(lim_lo_reg[1], lim_hi_reg[1]);
            CH_TEMP: lim = aux_lim(lim_lo_reg[2], lim_hi_reg[2]);
            CH_REF:  lim = '{lo: REF_LO, hi: REF_HI}; // R7
            CH_SUP:  lim = '{lo: SUP_LO, hi: SUP_HI}; // R7
            CH_CORE: lim = '{lo: CORE_LO, hi: CORE_HI}; // R8
            CH_BIAS: lim = '{lo: BIAS_LO, hi: BIAS_HI}; // R8
            CH_OUT: begin
                // clamp so the window never wraps
                lim.lo = (exp_code < OUT_MARGIN) ? LIM_ZERO : exp_code - OUT_MARGIN; // R9
                lim.hi = (exp_code > LIM_FULL - OUT_MARGIN) ? LIM_FULL
                                                            : exp_code + OUT_MARGIN; // R9
            end
            default: lim = aux_lim(lim_lo_reg[0], lim_hi_reg[0]);
        endcase
    end

    assign res_x       = {1'b0, CONV.result};
    assign alarm_hysteresis_x      = (RW+1)'(alarm_hysteresis_reg); // R26
    assign ch_disabled = (CONV.ch <= CH_TEMP) && (lim.lo == LIM_ZERO)
                         && (lim.hi == LIM_FULL); // R5
    assign out_of_lim  = !ch_disabled && ((CONV.result < lim.lo)
                         || (CONV.result > lim.hi)); // R4
    // below hi minus alarm_hysteresis and above lo plus alarm_hysteresis, without underflow
    assign inside_alarm_hysteresis = (res_x + alarm_hysteresis_x < {1'b0, lim.hi})
                         && (res_x > {1'b0, lim.lo} + alarm_hysteresis_x); // R3

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            alarm_reg <= '0;
            for (int i = 0; i < NCH; i++) begin
                fail_cnt_reg[i] <= '0;
            end
        end else if (CONV.valid) begin // R27
            if (alarm_reg[CONV.ch]) begin
                if (inside_alarm_hysteresis || ch_disabled) begin
                    alarm_reg[CONV.ch] <= 1'b0; // R3
                end
                fail_cnt_reg[CONV.ch] <= '0;
            end else if (out_of_lim) begin // R2
                if (fail_cnt_reg[CONV.ch] == flt_limit_reg) begin
                    alarm_reg[CONV.ch]    <= 1'b1; // R1
                    fail_cnt_reg[CONV.ch] <= '0;
                end else begin
                    fail_cnt_reg[CONV.ch] <= fail_cnt_reg[CONV.ch] + 1'b1; // R1
                end
            end else begin
                fail_cnt_reg[CONV.ch] <= '0; // R25
            end
        end
    end

    dai_queue u_txq (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .push      (SER_CH.valid && SER_CH.stop_ok), // R23
        .push_data (SER_CH.data),
        .pop       (TXQ_POP),
        .head      (TXQ_DATA),
        .empty     (tx_empty),
        .full      (tx_full)
    );

    dai_queue u_rxq (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .push      (DEMOD_CH.valid && DEMOD_CH.stop_ok), // R22
        .push_data (DEMOD_CH.data),
        .pop       (RXQ_POP),
        .head      (RXQ_DATA),
        .empty     (rx_empty),
        .full      (rx_full)
    );

    assign TXQ_VALID = !tx_empty;
    assign RXQ_VALID = !rx_empty;

    assign gen_cond = SER_CH.valid && !SER_CH.stop_ok; // R23
    always_comb begin
        mdm_cond             = '0;
        mdm_cond[MS_RXFE]    = DEMOD_CH.valid && !DEMOD_CH.stop_ok; // R22
        mdm_cond[MS_TXEMPTY] = tx_empty;
        mdm_cond[MS_TXFULL]  = tx_full;
        mdm_cond[MS_RXEMPTY] = rx_empty;
        mdm_cond[MS_RXFULL]  = rx_full;
    end

    assign rd_gen = RD && hit(ADDR, GEN_ST_OFS);
    assign rd_mdm = RD && hit(ADDR, MDM_ST_OFS);
    assign rd_alm = RD && hit(ADDR, ALM_ST_OFS);

    // register writes
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            config_reg    <= CONFIG_RST; // R13
            flt_limit_reg <= '0;
            alarm_hysteresis_reg      <= '0;
            gen_msk_reg   <= '1; // R11
            mdm_msk_reg   <= '1; // R11
            alm_msk_reg   <= '1; // R11
            for (int i = 0; i < 3; i++) begin
                lim_lo_reg[i] <= LIM_LO_RST; // R5
                lim_hi_reg[i] <= LIM_HI_RST; // R5
            end
        end else if (WR) begin
            if (hit(ADDR, CONFIG_OFS)) begin
                config_reg <= WDATA[2:0];
            end
            if (hit(ADDR, ADC_CFG_OFS)) begin
                flt_limit_reg <= WDATA[FLT_LSB +: FLT_W];
                alarm_hysteresis_reg      <= WDATA[ALARM_HYSTERESIS_LSB +: ALARM_HYSTERESIS_W];
            end
            if (hit(ADDR, AUX0_LIM_OFS)) begin
                lim_lo_reg[0] <= WDATA[LIM_LO_LSB +: 8];
                lim_hi_reg[0] <= WDATA[LIM_HI_LSB +: 8];
            end
            if (hit(ADDR, AUX1_LIM_OFS)) begin
                lim_lo_reg[1] <= WDATA[LIM_LO_LSB +: 8];
                lim_hi_reg[1] <= WDATA[LIM_HI_LSB +: 8];
            end
            if (hit(ADDR, TEMP_LIM_OFS)) begin
                lim_lo_reg[2] <= WDATA[LIM_LO_LSB +: 8];
                lim_hi_reg[2] <= WDATA[LIM_HI_LSB +: 8];
            end
            if (hit(ADDR, GEN_MSK_OFS)) begin
                gen_msk_reg <= WDATA[GEN_W-1:0];
            end
            if (hit(ADDR, MDM_MSK_OFS)) begin
                mdm_msk_reg <= WDATA[MDM_W-1:0];
            end
            if (hit(ADDR, ALM_MSK_OFS)) begin
                alm_msk_reg <= WDATA[NCH-1:0];
            end
        end
    end

    // sticky status; a set in the read cycle wins over the clear
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            gen_st_reg     <= '0;
            mdm_st_reg     <= '0;
            alm_st_reg     <= '0;
            mdm_cond_d_reg <= '0;
            alm_cond_d_reg <= '0;
        end else begin
            gen_st_reg <= gen_cond | (rd_gen ? '0 : gen_st_reg); // R12
            mdm_st_reg[MS_RXFE] <= mdm_cond[MS_RXFE]
                                   | (!rd_mdm && mdm_st_reg[MS_RXFE]); // R12
            mdm_st_reg[MDM_W-1:1] <= mdm_cond[MDM_W-1:1]; // R20
            alm_st_reg <= alarm_reg | (rd_alm ? '0 : alm_st_reg); // R12
            mdm_cond_d_reg <= mdm_cond;
            alm_cond_d_reg <= alarm_reg;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rdata_reg <= '0;
        end else if (RD) begin
            case (ADDR)
                CONFIG_OFS:   rdata_reg <= DW'(config_reg);
                ADC_CFG_OFS:  rdata_reg <= DW'({alarm_hysteresis_reg, 4'h0, flt_limit_reg});
                AUX0_LIM_OFS: rdata_reg <= DW'({lim_hi_reg[0], lim_lo_reg[0]});
                AUX1_LIM_OFS: rdata_reg <= DW'({lim_hi_reg[1], lim_lo_reg[1]});
                TEMP_LIM_OFS: rdata_reg <= DW'({lim_hi_reg[2], lim_lo_reg[2]});
                GEN_ST_OFS:   rdata_reg <= DW'(gen_st_reg);
                GEN_MSK_OFS:  rdata_reg <= DW'(gen_msk_reg);
                MDM_ST_OFS:   rdata_reg <= DW'(mdm_st_reg);
                MDM_MSK_OFS:  rdata_reg <= DW'(mdm_msk_reg);
                ALM_ST_OFS:   rdata_reg <= DW'(alm_st_reg);
                ALM_MSK_OFS:  rdata_reg <= DW'(alm_msk_reg);
                default:      rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end
    assign RDATA = rdata_reg;

    // level requests from unmasked sticky copies
    assign interrupt_mode_select = config_reg[CFG_IRQEN_BIT]
                     && ((|(gen_st_reg & ~gen_msk_reg))
                     || (|(mdm_st_reg & ~mdm_msk_reg))); // R14 R17 R18 R19
    assign alm_lvl = |(alm_st_reg & ~alm_msk_reg); // R14 R17 R19

    // edge requests from per bit assertion events
    assign irq_evt = config_reg[CFG_IRQEN_BIT]
                     && ((|(gen_cond & ~gen_msk_reg))
                     || (|(mdm_cond & ~mdm_cond_d_reg & ~mdm_msk_reg))); // R17 R18
    assign alm_evt = |(alarm_reg & ~alm_cond_d_reg & ~alm_msk_reg); // R17 R18

    always_ff @(posedge MCLK) begin
        if (!RST_N || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end
    assign tick = (tick_cnt_reg == 8'(TICK_CYC - 1)); // R16

    dai_edge_gen u_irq_edge (
        .clk   (MCLK),
        .rst_n (RST_N),
        .evt   (irq_evt),
        .tick  (tick),
        .pulse (irq_pulse)
    );

    dai_edge_gen u_alm_edge (
        .clk   (MCLK),
        .rst_n (RST_N),
        .evt   (alm_evt),
        .tick  (tick),
        .pulse (alm_pulse)
    );

    // pins: mode select then polarity
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            IRQ   <= 1'b1;
            ALARM <= 1'b1;
        end else begin
            IRQ   <= (config_reg[CFG_MODE_BIT] ? interrupt_mode_select : irq_pulse)
                     ~^ config_reg[CFG_POL_BIT]; // R13 R15 R19
            ALARM <= (config_reg[CFG_MODE_BIT] ? alm_lvl : alm_pulse)
                     ~^ config_reg[CFG_POL_BIT]; // R13 R15 R19
        end
    end
endmodule

// holds an event until the slow tick, then emits one fixed pulse
module dai_edge_gen
    import dai_pkg::*;
(
    input  wire logic clk,   // block clock
    input  wire logic rst_n, // synchronous reset
    input  wire logic evt,   // one-cycle event
    input  wire logic tick,  // slow clock tick
    output logic      pulse  // interrupt pulse
);
    dai_edge_e  state_reg;
    logic [5:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= DAI_IDLE;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                DAI_IDLE: begin
                    if (evt) begin
                        state_reg <= DAI_WAIT;
                    end
                end
                DAI_WAIT: begin
                    if (tick) begin
                        state_reg <= DAI_PULSE; // R16
                        cnt_reg   <= '0;
                    end
                end
                DAI_PULSE: begin
                    if (cnt_reg == 6'(PULSE_CYC - 1)) begin
                        state_reg <= evt ? DAI_WAIT : DAI_IDLE; // R13
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: state_reg <= DAI_IDLE;
            endcase
        end
    end
    assign pulse = (state_reg == DAI_PULSE);
endmodule

// ==== rtl/dai_pkg.sv ====
// constants and carrier types for the diagnostic alarm and interrupt block
package dai_pkg;
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          SLOW_CLK_HZ   = 307_200;
    localparam int          TICK_CYC      = CLK_HZ / SLOW_CLK_HZ;
    localparam int          PULSE_NS      = 813;
    localparam int          PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;

    localparam int          AW            = 8;
    localparam int          DW            = 32;
    localparam int          RW            = 12;
    localparam int          NCH           = 8;
    localparam int          QW            = 9;
    localparam int          QDEPTH        = 32;
    localparam int          QPW           = 5;

    // register byte offsets
    localparam logic [7:0]  CONFIG_OFS    = 8'h00;
    localparam logic [7:0]  ADC_CFG_OFS   = 8'h04;
    localparam logic [7:0]  AUX0_LIM_OFS  = 8'h08;
    localparam logic [7:0]  AUX1_LIM_OFS  = 8'h0C;
    localparam logic [7:0]  TEMP_LIM_OFS  = 8'h10;
    localparam logic [7:0]  GEN_ST_OFS    = 8'h14;
    localparam logic [7:0]  GEN_MSK_OFS   = 8'h18;
    localparam logic [7:0]  MDM_ST_OFS    = 8'h1C;
    localparam logic [7:0]  MDM_MSK_OFS   = 8'h20;
    localparam logic [7:0]  ALM_ST_OFS    = 8'h24;
    localparam logic [7:0]  ALM_MSK_OFS   = 8'h28;

    // field positions
    localparam int          CFG_MODE_BIT  = 0;
    localparam int          CFG_POL_BIT   = 1;
    localparam int          CFG_IRQEN_BIT = 2;
    localparam int          FLT_LSB       = 0;
    localparam int          FLT_W         = 4;
    localparam int          ALARM_HYSTERESIS_LSB      = 8;
    localparam int          ALARM_HYSTERESIS_W        = 7;
    localparam int          LIM_LO_LSB    = 0;
    localparam int          LIM_HI_LSB    = 8;
    localparam int          GEN_W         = 1;
    localparam int          MDM_W         = 5;

    // reset values
    localparam logic [2:0]  CONFIG_RST    = 3'h1;
    localparam logic [7:0]  LIM_LO_RST    = 8'h00;
    localparam logic [7:0]  LIM_HI_RST    = 8'hFF;

    // limit fill and fixed diagnostic windows
    localparam logic [3:0]  HI_FILL       = 4'hF;
    localparam logic [3:0]  LO_FILL       = 4'h0;
    localparam logic [11:0] LIM_ZERO      = 12'h000;
    localparam logic [11:0] LIM_FULL      = 12'hFFF;
    localparam logic [11:0] REF_LO        = 12'h6D0;
    localparam logic [11:0] REF_HI        = 12'h92F;
    localparam logic [11:0] SUP_LO        = 12'h310;
    localparam logic [11:0] SUP_HI        = 12'hD3F;
    localparam logic [11:0] CORE_LO       = 12'h9C0;
    localparam logic [11:0] CORE_HI       = 12'hD3F;
    localparam logic [11:0] BIAS_LO       = 12'h690;
    localparam logic [11:0] BIAS_HI       = 12'h8CF;
    localparam logic [11:0] OUT_MARGIN    = 12'h040;

    // channel numbering
    localparam logic [2:0]  CH_AUX0       = 3'h0;
    localparam logic [2:0]  CH_AUX1       = 3'h1;
    localparam logic [2:0]  CH_TEMP       = 3'h2;
    localparam logic [2:0]  CH_REF        = 3'h3;
    localparam logic [2:0]  CH_SUP        = 3'h4;
    localparam logic [2:0]  CH_CORE       = 3'h5;
    localparam logic [2:0]  CH_BIAS       = 3'h6;
    localparam logic [2:0]  CH_OUT        = 3'h7;

    // modem status bits
    localparam int          MS_RXFE       = 0;
    localparam int          MS_TXEMPTY    = 1;
    localparam int          MS_TXFULL     = 2;
    localparam int          MS_RXEMPTY    = 3;
    localparam int          MS_RXFULL     = 4;

    typedef struct packed {
        logic          valid;
        logic [2:0]    ch;
        logic [RW-1:0] result;
    } dai_conv_s;

    typedef struct packed {
        logic          valid;
        logic          stop_ok;
        logic [QW-1:0] data;
    } dai_char_s;

    typedef struct packed {
        logic [RW-1:0] lo;
        logic [RW-1:0] hi;
    } dai_limit_s;

    typedef enum logic [1:0] {
        DAI_IDLE  = 2'b00,
        DAI_WAIT  = 2'b01,
        DAI_PULSE = 2'b10
    } dai_edge_e;
endpackage

// ==== dv/dai_chk.sv ====
// assertion checker for the alarm and interrupt block pins
`timescale 1ns/1ps
module dai_chk
    import dai_pkg::*;
(
    input wire logic                 MCLK,      // block clock
    input wire logic                 RST_N,     // synchronous reset, low
    input wire dai_pkg::dai_char_s   DEMOD_CH,  // demodulated character
    input wire dai_pkg::dai_char_s   SER_CH,    // serial input character
    input wire logic                 TXQ_POP,   // transmit queue pop
    input wire logic [dai_pkg::QW-1:0] TXQ_DATA, // transmit queue head
    input wire logic                 TXQ_VALID, // transmit queue not empty
    input wire logic                 RXQ_POP,   // receive queue pop
    input wire logic [dai_pkg::QW-1:0] RXQ_DATA, // receive queue head
    input wire logic                 RXQ_VALID, // receive queue not empty
    input wire logic                 IRQ,       // interrupt pin
    input wire logic                 ALARM      // alarm pin
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    property p_rst; $rose(RST_N) |-> IRQ && ALARM && !TXQ_VALID && !RXQ_VALID; endproperty
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
    property p_ser_bad; SER_CH.valid && !SER_CH.stop_ok && !TXQ_VALID |=> !TXQ_VALID; endproperty
    a_ser_bad: assert property (p_ser_bad) else $error("bad serial char queued");
    property p_dem_bad; DEMOD_CH.valid && !DEMOD_CH.stop_ok && !RXQ_VALID |=> !RXQ_VALID; endproperty
    a_dem_bad: assert property (p_dem_bad) else $error("bad demod char queued");
    property p_ser_ok; SER_CH.valid && SER_CH.stop_ok |=> TXQ_VALID; endproperty
    a_ser_ok: assert property (p_ser_ok) else $error("serial char lost");
    property p_dem_ok; DEMOD_CH.valid && DEMOD_CH.stop_ok |=> RXQ_VALID; endproperty
    a_dem_ok: assert property (p_dem_ok) else $error("demod char lost");
    property p_tx_hold; TXQ_VALID && !TXQ_POP |=> TXQ_VALID && $stable(TXQ_DATA); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit head moved");
    property p_rx_hold; RXQ_VALID && !RXQ_POP |=> RXQ_VALID && $stable(RXQ_DATA); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive head moved");
    property p_rx_last; $rose(RXQ_VALID) && !DEMOD_CH.valid
        ##1 RXQ_POP && !DEMOD_CH.valid |=> !RXQ_VALID; endproperty
    a_rx_last: assert property (p_rx_last) else $error("empty flag stale");
endmodule

// ==== dv/dai_host_mdl.sv ====
// host-side consumer that drains one character queue
`timescale 1ns/1ps
module dai_host_mdl (
    input  wire logic clk,   // block clock
    input  wire logic en,    // drain enable
    input  wire logic valid, // queue not empty
    output logic      pop    // take head
);
    // every other cycle, so a stale valid is never popped twice
    always_ff @(posedge clk) begin
        pop <= en && valid && !pop;
    end
endmodule

// ==== dv/test_dai_top.sv ====
// self-checking bench for the alarm and interrupt block
`timescale 1ns/1ps
module test_dai_top;
    import dai_pkg::*;
    logic          mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0, rdata;
    dai_conv_s     conv = '0;
    dai_char_s     dem = '0, ser = '0;
    logic          txp, rxp, txv, rxv, irq, alarm, en_tx = 1'b0;
    logic [QW-1:0] txd, rxd;
    int            num_errors = 0, samples_checked = 0, cyc = 0, n;
    logic [11:0]   seq [5] = '{12'h6CF, 12'h6CF, 12'h800, 12'h930, 12'h6CF};
    logic [2:0]    tch [6] = '{CH_AUX0, CH_REF, CH_SUP, CH_CORE, CH_BIAS, CH_OUT};
    logic [11:0]   thi [6] = '{12'h80F, REF_HI, SUP_HI, CORE_HI, BIAS_HI, 12'h840};

    dai_top dut_u (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .CONV(conv), .DAC_CODE(16'h8000), .DEMOD_CH(dem),
        .SER_CH(ser), .TXQ_POP(txp), .TXQ_DATA(txd), .TXQ_VALID(txv), .RXQ_POP(rxp),
        .RXQ_DATA(rxd), .RXQ_VALID(rxv), .IRQ(irq), .ALARM(alarm));
    dai_host_mdl tx_u (.clk(mclk), .en(en_tx), .valid(txv), .pop(txp));
    dai_host_mdl rx_u (.clk(mclk), .en(1'b1), .valid(rxv), .pop(rxp));

    initial begin
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            stop_test;
        end
    end

    task automatic stop_test;
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic cv(input logic [2:0] c, input logic [11:0] r);
        @(posedge mclk);
        conv <= '{1'b1, c, r};
        @(posedge mclk);
        conv.valid <= 1'b0;
    endtask
    task automatic chr(input logic s, input logic ok, input logic [8:0] d);
        @(posedge mclk);
        if (s) ser <= '{1'b1, ok, d};
        else dem <= '{1'b1, ok, d};
        @(posedge mclk);
        ser.valid <= 1'b0;
        dem.valid <= 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rchk(CONFIG_OFS, 32'h1);
        rchk(GEN_MSK_OFS, 32'h1);
        rchk(MDM_MSK_OFS, 32'h1F);
        rchk(ALM_MSK_OFS, 32'hFF);
        rchk(AUX0_LIM_OFS, 32'hFF00);
        rchk(8'hFC, 32'h0);
        chr(1'b1, 1'b1, 9'h1A5);
        #1 chk({23'h0, txd}, 32'h1A5);
        chr(1'b1, 1'b0, 9'h0FF);
        rchk(GEN_ST_OFS, 32'h1);
        rchk(GEN_ST_OFS, 32'h0);
        chk({23'h0, txd}, 32'h1A5);
        rchk(MDM_ST_OFS, 32'h08);
        chr(1'b0, 1'b0, 9'h055);
        rchk(MDM_ST_OFS, 32'h09);
        en_tx <= 1'b1;
        repeat (4) @(posedge mclk);
        rchk(MDM_ST_OFS, 32'h0A);
        chr(1'b0, 1'b1, 9'h1C3);
        #1 chk({23'h0, rxd}, 32'h1C3);
        // fault count and hysteresis
        wreg(ADC_CFG_OFS, 32'h1002);
        wreg(ALM_MSK_OFS, 32'hF7);
        foreach (seq[i]) cv(CH_REF, seq[i]);
        repeat (4) @(posedge mclk);
        chk({31'h0, alarm}, 32'h1);
        cv(CH_REF, 12'h930);
        repeat (4) @(posedge mclk);
        chk({31'h0, alarm}, 32'h0);
        cv(CH_REF, 12'h920);
        rchk(ALM_ST_OFS, 32'h08);
        cv(CH_REF, 12'h91E);
        repeat (4) @(posedge mclk);
        chk({31'h0, alarm}, 32'h0);
        rchk(ALM_ST_OFS, 32'h08);
        repeat (3) @(posedge mclk);
        chk({31'h0, alarm}, 32'h1);
        rchk(ALM_ST_OFS, 32'h0);
        // upper window edges
        wreg(ADC_CFG_OFS, 32'h0);
        wreg(AUX0_LIM_OFS, 32'h8010);
        foreach (tch[i]) cv(tch[i], thi[i]);
        rchk(ALM_ST_OFS, 32'h0);
        foreach (tch[i]) cv(tch[i], thi[i] + 12'h1);
        rchk(ALM_ST_OFS, 32'hF9);
        // edge mode, late unmask
        wreg(CONFIG_OFS, 32'h6);
        chr(1'b1, 1'b0, 9'h000);
        wreg(GEN_MSK_OFS, 32'h0);
        n = 0;
        repeat (300) @(posedge mclk) n += irq;
        chk(n, 0);
        chr(1'b1, 1'b0, 9'h000);
        n = 0;
        repeat (300) @(posedge mclk) n += irq;
        chk(n, PULSE_CYC);
        wreg(CONFIG_OFS, 32'h5);
        rchk(GEN_ST_OFS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        stop_test;
    end
endmodule

bind dai_top dai_chk chk_u (.MCLK(MCLK), .RST_N(RST_N), .DEMOD_CH(DEMOD_CH),
    .SER_CH(SER_CH), .TXQ_POP(TXQ_POP), .TXQ_DATA(TXQ_DATA), .TXQ_VALID(TXQ_VALID),
    .RXQ_POP(RXQ_POP), .RXQ_DATA(RXQ_DATA), .RXQ_VALID(RXQ_VALID), .IRQ(IRQ),
    .ALARM(ALARM));
